// ---- rtl/secd_decoder.sv ----
// Purpose: serial slave decoding the extended command set of a packet radio
// Assumes: link pins oversampled by core_clk_i; link clock at most 8 MHz
// Notes: register contents live in the core; this block streams writes out
//
// Summary of operation
// - unlock byte then 0x73 toggles extra commands
// - repeating it disables them again
// - unlock only in power-down or standby
// - extras start off; ignored writes, zero reads
// - unlock then 0x53 toggles bank, bit7 status_reg_seven forced to 0 in bank 0 only
// - width command returns receive head length
// - ack payload pipe in low bits, 0-5
// - at most three pending ack payloads
// - same-pipe ack payloads leave in order
// - one to 32 bytes, from byte zero
// - unacked transmit write disables acknowledge once
// - all-ones byte is no operation
// - bank 0, bank-1 regs 9-14 LSB byte first
// - bank-1 regs 0-8 MSB byte first
// - status shifts out during command byte
module secd_decoder (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic mosi_i,
    input wire logic chip_select_n_i,
    output logic miso_o,
    output logic miso_oe_o,
    input wire logic [7:0] status_i,
    input wire logic standby_i,
    input wire logic [7:0] rx_width_i,
    output secd_pkg::secd_rd_req_t rd_req_o,
    input wire logic [7:0] reg_rd_data_i,
    input wire logic ack_payload_sent_i,
    output logic beat_valid_o,
    input wire logic beat_ready_i,
    output secd_pkg::secd_beat_t beat_o,
    output logic features_on_o,
    output logic bank_sel_o,
    output logic [1:0] ack_pending_o,
    output logic overrun_o
);
    import secd_pkg::*;

    // two-stage synchronisers plus one history stage for edges
    logic [2:0] sclk_sync_reg, csn_sync_reg, sclk_sync_next, csn_sync_next;
    logic [1:0] mosi_sync_reg, mosi_sync_next;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, csn_s, mosi_s;

    always_comb begin
        sclk_sync_next = {sclk_sync_reg[1:0], sclk_i};
        csn_sync_next = {csn_sync_reg[1:0], chip_select_n_i};
        mosi_sync_next = {mosi_sync_reg[0], mosi_i};
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            sclk_sync_reg <= 3'h0;
            csn_sync_reg <= 3'h7;
            mosi_sync_reg <= 2'h0;
        end else begin
            sclk_sync_reg <= sclk_sync_next;
            csn_sync_reg <= csn_sync_next;
            mosi_sync_reg <= mosi_sync_next;
        end
    end

    // edge pulses act as one-cycle enables on the core clock
    assign sclk_rise = sclk_sync_reg[1] && !sclk_sync_reg[2];
    assign sclk_fall = !sclk_sync_reg[1] && sclk_sync_reg[2];
    assign cs_fall = !csn_sync_reg[1] && csn_sync_reg[2];
    assign cs_rise = csn_sync_reg[1] && !csn_sync_reg[2];
    assign csn_s = csn_sync_reg[1];
    assign mosi_s = mosi_sync_reg[1];

    // frame state
    secd_state_t st_reg, st_next;
    secd_kind_t kind_reg, kind_next;
    logic [4:0] target_reg, target_next;
    logic [2:0] bit_reg, bit_next;
    logic [5:0] byte_reg, byte_next;
    logic [7:0] rxs_reg, rxs_next, txs_reg, txs_next, nxt_reg, nxt_next;
    logic fetch_reg, fetch_next, load_reg, load_next;
    logic miso_reg, miso_next, oe_reg, oe_next;
    logic feat_reg, feat_next, bank_reg, bank_next;
    logic [1:0] ack_cnt_reg, ack_cnt_next;
    logic ovr_reg, ovr_next;
    secd_rd_req_t rdq_reg, rdq_next;
    secd_beat_t pend_reg, pend_next, fifo_data;
    logic pend_v_reg, pend_v_next, fifo_in_ready, ack_done;
    logic [7:0] rx_byte, rd_byte;

    assign rx_byte = {rxs_reg[6:0], mosi_s};

    // byte returned on a read: register data, width, or zeros when locked
    always_comb begin
        rd_byte = 8'h00;
        if (kind_reg == K_REG_RD) begin
            rd_byte = reg_rd_data_i;
            if (!bank_reg && rdq_reg.addr == BANK_STATUS_ADDR && rdq_reg.index == 6'h00) begin
                rd_byte[BANK_STATUS_BIT] = bank_reg;
            end
        end else if (kind_reg == K_RX_WIDTH && feat_reg) begin
            rd_byte = rx_width_i;
        end
    end

    // main decode; a queued beat that is still waiting when the next one comes is an overrun
    always_comb begin
        st_next = st_reg;
        kind_next = kind_reg;
        target_next = target_reg;
        bit_next = bit_reg;
        byte_next = byte_reg;
        rxs_next = rxs_reg;
        txs_next = txs_reg;
        nxt_next = nxt_reg;
        fetch_next = 1'b0;
        load_next = load_reg;
        miso_next = miso_reg;
        oe_next = oe_reg;
        feat_next = feat_reg;
        bank_next = bank_reg;
        ovr_next = ovr_reg;
        rdq_next = rdq_reg;
        pend_next = pend_reg;
        pend_v_next = pend_v_reg && !fifo_in_ready;
        ack_done = 1'b0;
        if (fetch_reg) begin
            nxt_next = rd_byte;
            load_next = 1'b1;
        end
        if (cs_fall) begin
            st_next = ST_CMD;
            kind_next = K_NONE;
            bit_next = 3'h0;
            byte_next = 6'h00;
            load_next = 1'b0;
            // status leaves with the command byte
            miso_next = status_i[7];
            txs_next = {status_i[6:0], 1'b0};
            oe_next = 1'b1;
            ovr_next = 1'b0;
        end else if (cs_rise) begin
            st_next = ST_IDLE;
            oe_next = 1'b0;
            if (st_reg == ST_DATA && byte_reg != 6'h00 &&
                (kind_reg == K_REG_WR || kind_reg == K_ACK_PL || kind_reg == K_NOACK_PL)) begin
                if (pend_v_next) begin
                    ovr_next = 1'b1;
                end else begin
                    // end count saturates at the stored length, so dropped bytes are not reported
                    pend_next = '{kind_reg, 1'b1, target_reg, (byte_reg > PAYLOAD_MAX) ? PAYLOAD_MAX : byte_reg,
                        rdq_reg.msb_first, 8'h00};
                    pend_v_next = 1'b1;
                end
                ack_done = (kind_reg == K_ACK_PL);
            end
        end else if (!csn_s && sclk_rise && st_reg != ST_IDLE) begin
            rxs_next = rx_byte;
            bit_next = bit_reg + 3'h1;
            if (bit_reg == 3'h7) begin
                fetch_next = 1'b1;
                if (st_reg == ST_CMD) begin
                    st_next = ST_DATA;
                    byte_next = 6'h00;
                    target_next = rx_byte[4:0];
                    kind_next = K_NONE;
                    if (rx_byte[7:5] == CMD_REG_RD_TOP) begin
                        kind_next = K_REG_RD;
                    end else if (rx_byte[7:5] == CMD_REG_WR_TOP) begin
                        kind_next = K_REG_WR;
                    end else if (rx_byte == CMD_ACTIVATE) begin
                        kind_next = K_ACTIVATE;
                    end else if (rx_byte == CMD_RX_WIDTH) begin
                        kind_next = K_RX_WIDTH;
                    end else if (rx_byte[7:3] == CMD_ACK_PL_TOP) begin
                        if (feat_reg && rx_byte[2:0] <= PIPE_LAST && ack_cnt_reg != ACK_SLOTS) begin
                            kind_next = K_ACK_PL;
                            target_next = {2'b00, rx_byte[2:0]};
                        end
                    end else if (rx_byte == CMD_NOACK_PL) begin
                        if (feat_reg) begin
                            kind_next = K_NOACK_PL;
                        end
                    end else if (rx_byte == CMD_IDLE_STATUS) begin
                        kind_next = K_NONE;
                    end
                    rdq_next.addr = rx_byte[4:0];
                    rdq_next.index = 6'h00;
                    rdq_next.msb_first = bank_reg && rx_byte[4:0] <= BANK1_REV_LAST;
                end else begin
                    if (byte_reg != 6'h3F) begin
                        byte_next = byte_reg + 6'h01;
                    end
                    rdq_next.index = byte_next;
                    if (kind_reg == K_ACTIVATE && byte_reg == 6'h00 && standby_i) begin
                        if (rx_byte == ACT_FEATURES) begin
                            feat_next = !feat_reg;
                        end
                        if (rx_byte == ACT_BANK) begin
                            bank_next = !bank_reg;
                        end
                    end
                    // bytes past 32 are dropped; index counts from zero
                    if ((kind_reg == K_REG_WR || kind_reg == K_ACK_PL || kind_reg == K_NOACK_PL) &&
                        byte_reg < PAYLOAD_MAX) begin
                        if (pend_v_next) begin
                            ovr_next = 1'b1;
                        end else begin
                            pend_next = '{kind_reg, 1'b0, target_reg, byte_reg, rdq_reg.msb_first, rx_byte};
                            pend_v_next = 1'b1;
                        end
                    end
                end
            end
        end else if (!csn_s && sclk_fall && st_reg != ST_IDLE) begin
            if (load_reg) begin
                miso_next = nxt_reg[7];
                txs_next = {nxt_reg[6:0], 1'b0};
                load_next = 1'b0;
            end else begin
                miso_next = txs_reg[7];
                txs_next = {txs_reg[6:0], 1'b0};
            end
        end
    end

    // pending ack count; a send and a new payload together cancel
    always_comb begin
        ack_cnt_next = ack_cnt_reg;
        if (ack_done && !ack_payload_sent_i) begin
            ack_cnt_next = ack_cnt_reg + 2'h1;
        end else if (!ack_done && ack_payload_sent_i && ack_cnt_reg != 2'h0) begin
            ack_cnt_next = ack_cnt_reg - 2'h1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= ST_IDLE;
            kind_reg <= K_NONE;
            target_reg <= 5'h00;
            bit_reg <= 3'h0;
            byte_reg <= 6'h00;
            rxs_reg <= 8'h00;
            txs_reg <= 8'h00;
            nxt_reg <= 8'h00;
            fetch_reg <= 1'b0;
            load_reg <= 1'b0;
            miso_reg <= 1'b0;
            oe_reg <= 1'b0;
            feat_reg <= FEATURES_RESET;
            bank_reg <= BANK_RESET;
            ack_cnt_reg <= 2'h0;
            ovr_reg <= 1'b0;
            rdq_reg <= '0;
            pend_reg <= '0;
            pend_v_reg <= 1'b0;
        end else begin
            st_reg <= st_next;
            kind_reg <= kind_next;
            target_reg <= target_next;
            bit_reg <= bit_next;
            byte_reg <= byte_next;
            rxs_reg <= rxs_next;
            txs_reg <= txs_next;
            nxt_reg <= nxt_next;
            fetch_reg <= fetch_next;
            load_reg <= load_next;
            miso_reg <= miso_next;
            oe_reg <= oe_next;
            feat_reg <= feat_next;
            bank_reg <= bank_next;
            ack_cnt_reg <= ack_cnt_next;
            ovr_reg <= ovr_next;
            rdq_reg <= rdq_next;
            pend_reg <= pend_next;
            pend_v_reg <= pend_v_next;
        end
    end

    // one queue keeps write order, so same-pipe payloads stay in order
    assign fifo_data = pend_reg;
    secd_fifo #(
        .WIDTH($bits(secd_beat_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .in_valid_i(pend_v_reg),
        .in_ready_o(fifo_in_ready),
        .in_data_i(fifo_data),
        .out_valid_o(beat_valid_o),
        .out_ready_i(beat_ready_i),
        .out_data_o(beat_o)
    );

    // outputs from flops
    assign miso_o = miso_reg;
    assign miso_oe_o = oe_reg;
    assign rd_req_o = rdq_reg;
    assign features_on_o = feat_reg;
    assign bank_sel_o = bank_reg;
    assign ack_pending_o = ack_cnt_reg;
    assign overrun_o = ovr_reg;
endmodule // secd_decoder

// ---- rtl/secd_pkg.sv ----
// Purpose: shared constants and types for the serial extended-command decoder
// Assumes: one core clock, serial link sampled as plain inputs
// Notes: command codes and bank layout live here only
package secd_pkg;

    // command bytes and their data values
    localparam logic [7:0] CMD_ACTIVATE = 8'h50;
    localparam logic [7:0] ACT_FEATURES = 8'h73;
    localparam logic [7:0] ACT_BANK = 8'h53;
    localparam logic [7:0] CMD_RX_WIDTH = 8'h60;
    localparam logic [4:0] CMD_ACK_PL_TOP = 5'h15;
    localparam logic [7:0] CMD_NOACK_PL = 8'hB0;
    localparam logic [7:0] CMD_IDLE_STATUS = 8'hFF;
    localparam logic [2:0] CMD_REG_RD_TOP = 3'h0;
    localparam logic [2:0] CMD_REG_WR_TOP = 3'h1;

    // limits
    localparam logic [2:0] PIPE_LAST = 3'h5;
    localparam logic [5:0] PAYLOAD_MAX = 6'h20;
    localparam logic [1:0] ACK_SLOTS = 2'h3;
    localparam int FIFO_DEPTH = 4;

    // bank status bit and reversed-order range in bank 1
    localparam logic [4:0] BANK_STATUS_ADDR = 5'h07;
    localparam int BANK_STATUS_BIT = 7;
    localparam logic [4:0] BANK1_REV_LAST = 5'h08;

    // reset values
    localparam logic BANK_RESET = 1'h0;
    localparam logic FEATURES_RESET = 1'h0;

    // kind of a beat handed to the core
    typedef enum logic [2:0] {
        K_NONE = 3'h0,
        K_REG_RD = 3'h1,
        K_REG_WR = 3'h2,
        K_ACTIVATE = 3'h3,
        K_RX_WIDTH = 3'h4,
        K_ACK_PL = 3'h5,
        K_NOACK_PL = 3'h6
    } secd_kind_t;

    // frame state, one-hot
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CMD = 3'b010,
        ST_DATA = 3'b100
    } secd_state_t;

    // one written byte, or an end-of-frame marker (frame_end set, data zero)
    typedef struct packed {
        secd_kind_t kind;
        logic frame_end;
        logic [4:0] target;
        logic [5:0] index;
        logic msb_first;
        logic [7:0] data;
    } secd_beat_t;

    // read request towards the register file of the core
    typedef struct packed {
        logic [4:0] addr;
        logic [5:0] index;
        logic msb_first;
    } secd_rd_req_t;

endpackage

// ---- rtl/secd_fifo.sv ----
// Purpose: small shift FIFO carrying decoded write beats to the core
// Assumes: same clock on both sides
// Notes: the head is always entry 0, so the output comes straight from flops
module secd_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 4
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [WIDTH-1:0] mem_next [DEPTH];
    logic [CW-1:0] cnt_reg, cnt_next;
    logic push, pop;

    assign in_ready_o = (cnt_reg != CW'(DEPTH));
    assign out_valid_o = (cnt_reg != '0);
    assign out_data_o = mem_reg[0];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // each entry shifts down on a pop and takes the new word at the tail
    generate
        for (genvar i = 0; i < DEPTH; i++) begin : g_ent
            always_comb begin
                mem_next[i] = mem_reg[i];
                if (pop) begin
                    mem_next[i] = (i + 1 < DEPTH) ? mem_reg[(i + 1) % DEPTH] : '0;
                end
                if (push && (CW'(i) == (pop ? cnt_reg - CW'(1) : cnt_reg))) begin
                    mem_next[i] = in_data_i;
                end
            end
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    mem_reg[i] <= '0;
                end else begin
                    mem_reg[i] <= mem_next[i];
                end
            end
        end
    endgenerate

    // occupancy
    always_comb begin
        cnt_next = cnt_reg + CW'(push) - CW'(pop);
    end
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end
endmodule // secd_fifo

// ---- testbench/secd_props.sv ----
// Purpose: port-level checks on the extended command decoder
// Assumes: status_i is held constant by the bench
// Notes: bound to every decoder instance below
module secd_props (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic sclk_i,
    input wire logic chip_select_n_i,
    input wire logic miso_o,
    input wire logic miso_oe_o,
    input wire logic [7:0] status_i,
    input wire logic standby_i,
    input wire logic ack_payload_sent_i,
    input wire logic beat_valid_o,
    input wire logic beat_ready_i,
    input wire secd_pkg::secd_beat_t beat_o,
    input wire logic features_on_o,
    input wire logic bank_sel_o,
    input wire logic [1:0] ack_pending_o
);
    import secd_pkg::*;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    // select held long enough to pass the two-stage sync and the output flop
    sequence s_sel_idle;
        chip_select_n_i [*6];
    endsequence
    sequence s_sel_open;
        !chip_select_n_i [*6];
    endsequence

    a_reset_quiet:
    assert property (disable iff (1'b0) !rst_n_i |=> !miso_oe_o && !beat_valid_o && !features_on_o
        && !bank_sel_o && ack_pending_o == 2'h0) else $error("outputs not cleared by reset");
    a_feat_standby:
    assert property ($changed(features_on_o) |-> $past(standby_i)) else $error("unlock taken while awake");
    a_bank_standby:
    assert property ($changed(bank_sel_o) |-> $past(standby_i)) else $error("bank toggled while awake");
    a_ack_up:
    assert property (ack_pending_o == $past(ack_pending_o) + 2'h1 |-> $past(chip_select_n_i, 2) && features_on_o)
        else $error("ack count rose outside frame end");
    a_ack_down:
    assert property (ack_pending_o + 2'h1 == $past(ack_pending_o) |-> $past(ack_payload_sent_i)
        || $past(ack_payload_sent_i, 2)) else $error("ack count fell without a send");
    a_status_first:
    assert property ($rose(miso_oe_o) |-> miso_o == status_i[7]) else $error("first bit is not status msb");
    a_miso_fall:
    assert property (miso_oe_o && $past(miso_oe_o) && $changed(miso_o) |-> !$past(sclk_i, 2) && !$past(sclk_i, 3))
        else $error("serial out changed away from a falling clock");
    a_oe_idle:
    assert property (s_sel_idle |-> !miso_oe_o) else $error("serial out driven while deselected");
    a_oe_open:
    assert property (s_sel_open |-> miso_oe_o) else $error("serial out not driven in frame");
    a_beat_hold:
    assert property (beat_valid_o && !beat_ready_i |=> beat_valid_o && $stable(beat_o))
        else $error("stalled beat changed");
endmodule // secd_props

bind secd_decoder secd_props u_props (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk_i),
    .chip_select_n_i(chip_select_n_i), .miso_o(miso_o), .miso_oe_o(miso_oe_o), .status_i(status_i),
    .standby_i(standby_i), .ack_payload_sent_i(ack_payload_sent_i), .beat_valid_o(beat_valid_o),
    .beat_ready_i(beat_ready_i), .beat_o(beat_o), .features_on_o(features_on_o), .bank_sel_o(bank_sel_o),
    .ack_pending_o(ack_pending_o));

// ---- testbench/secd_host_model.sv ----
// Purpose: host controller acting as serial master, mode 0, 160 ns per bit
// Assumes: called from the bench at a rising core clock edge
// Notes: link clock stands low outside frames
module secd_host_model (
    input wire logic core_clk_i,
    input wire logic miso_i,
    output logic sclk_o,
    output logic mosi_o,
    output logic chip_select_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b0;
        chip_select_n_o = 1'b1;
    end

    // one frame: command byte then data, msb bit first, reply sampled on rises
    task automatic xfer(input logic [7:0] tx[$], output logic [7:0] rx[$]);
        logic [7:0] b;
        rx = {};
        chip_select_n_o <= 1'b0;
        repeat (8) @(posedge core_clk_i);
        foreach (tx[i]) begin
            for (int k = 7; k >= 0; k--) begin
                // data moves with the clock low, sampled on the rise
                @(posedge core_clk_i);
                sclk_o <= 1'b0;
                mosi_o <= tx[i][k];
                repeat (8) @(posedge core_clk_i);
                sclk_o <= 1'b1;
                b[k] = miso_i;
                repeat (7) @(posedge core_clk_i);
            end
            rx.push_back(b);
        end
        @(posedge core_clk_i);
        sclk_o <= 1'b0;
        mosi_o <= ~mosi_o; // released line shows no stale bit
        repeat (8) @(posedge core_clk_i);
        chip_select_n_o <= 1'b1;
        repeat (8) @(posedge core_clk_i);
    endtask
endmodule // secd_host_model

// ---- testbench/tb_top.sv ----
// Purpose: self-checking bench for the extended command decoder
// Assumes: core side modelled inline, beats gathered into a queue
// Notes: status byte held constant so the checker can rely on it
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import secd_pkg::*;
    localparam int LIMIT = 40000;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic standby_i = 1'b1;
    logic ack_payload_sent_i = 1'b0;
    logic beat_ready_i = 1'b1;
    logic [7:0] status_i = 8'hA5;
    logic [7:0] rx_width_i = 8'h1B;
    logic [7:0] reg_rd_data_i;
    logic sclk, mosi, chip_select_n, miso, miso_oe, beat_valid, features_on, bank_sel, overrun;
    logic [1:0] ack_pending;
    secd_rd_req_t rd_req;
    secd_beat_t beat;
    secd_beat_t beats[$];
    logic [7:0] rx[$];
    int num_checks = 0;
    int miscompares = 0;
    int cycles = 0;

    // register file stand-in: bit 7 set so the bank override is visible
    assign reg_rd_data_i = {1'b1, rd_req.index[1:0], rd_req.addr};

    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end

    secd_host_model host (.core_clk_i(core_clk_i), .miso_i(miso), .sclk_o(sclk), .mosi_o(mosi),
        .chip_select_n_o(chip_select_n));
    secd_decoder DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .mosi_i(mosi),
        .chip_select_n_i(chip_select_n), .miso_o(miso), .miso_oe_o(miso_oe), .status_i(status_i),
        .standby_i(standby_i), .rx_width_i(rx_width_i), .rd_req_o(rd_req), .reg_rd_data_i(reg_rd_data_i),
        .ack_payload_sent_i(ack_payload_sent_i), .beat_valid_o(beat_valid), .beat_ready_i(beat_ready_i),
        .beat_o(beat), .features_on_o(features_on), .bank_sel_o(bank_sel), .ack_pending_o(ack_pending),
        .overrun_o(overrun));

    // beat capture, and a cycle ceiling so a hang still reaches the report
    always @(posedge core_clk_i) begin
        if (beat_valid && beat_ready_i)
            beats.push_back(beat);
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // one frame, then time for the last beats to drain
    task automatic send(input logic [7:0] tx[$]);
        beats = {};
        host.xfer(tx, rx);
        repeat (12) @(posedge core_clk_i);
    endtask

    task automatic pulse_sent();
        ack_payload_sent_i <= 1'b1;
        @(posedge core_clk_i);
        ack_payload_sent_i <= 1'b0;
        repeat (3) @(posedge core_clk_i);
    endtask

    task automatic t_locked();
        chk("reset outs", {features_on, bank_sel, ack_pending, miso_oe, beat_valid, overrun}, 0);
        send('{CMD_IDLE_STATUS, 8'h3C});
        chk("idle status", rx[0], status_i);
        chk("idle beats", beats.size(), 0);
        send('{CMD_RX_WIDTH, 8'h5A});
        chk("locked width", rx[1], 8'h00);
        send('{8'hA8, 8'h5A});
        chk("locked ack", beats.size(), 0);
        send('{CMD_NOACK_PL, 8'h5A});
        chk("locked noack", beats.size(), 0);
        $display("test locked done");
    endtask

    task automatic t_activate();
        standby_i <= 1'b0;
        send('{CMD_ACTIVATE, ACT_FEATURES});
        send('{CMD_ACTIVATE, ACT_BANK});
        chk("awake refused", {features_on, bank_sel}, 2'b00);
        standby_i <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            send('{CMD_ACTIVATE, ACT_FEATURES});
            chk("unlock toggle", features_on, i[0] ? 1'b0 : 1'b1);
        end
        send('{CMD_RX_WIDTH, 8'h00});
        chk("width read", rx[1], 8'h1B);
        $display("test activate done");
    endtask

    task automatic t_bank();
        send('{8'h07, 8'h00});
        chk("bank bit", rx[1], 8'h07);
        send('{CMD_ACTIVATE, ACT_BANK});
        chk("bank one", bank_sel, 1'b1);
        send('{8'h28, 8'h11, 8'h22});
        chk("reversed", {beats[0].kind, beats[0].target, beats[0].msb_first, beats[1].data},
            {K_REG_WR, 5'h08, 1'b1, 8'h22});
        send('{8'h29, 8'h33, 8'h44});
        chk("forward", {beats[0].target, beats[0].msb_first, beats[1].index}, {5'h09, 1'b0, 6'h01});
        send('{CMD_ACTIVATE, ACT_BANK});
        chk("bank zero", bank_sel, 1'b0);
        $display("test bank done");
    endtask

    task automatic t_ack();
        logic [1:0] exp_n = 2'h0;
        for (int p = 0; p < 6; p++) begin
            if (exp_n == ACK_SLOTS) begin
                pulse_sent();
                exp_n--;
            end
            send('{8'hA8 | 8'(p), 8'(8'h30 + p), 8'(8'h40 + p)});
            exp_n++;
            chk("ack head", {beats[0].kind, beats[0].target, beats[0].index, beats[0].data},
                {K_ACK_PL, 5'(p), 6'h00, 8'(8'h30 + p)});
            chk("ack end", {beats[2].frame_end, beats[2].index, beats[1].data}, {1'b1, 6'h02, 8'(8'h40 + p)});
            chk("ack count", ack_pending, exp_n);
        end
        send('{8'hAB, 8'h55});
        chk("ack full", {beats.size() == 0, ack_pending}, 3'b111);
        pulse_sent();
        for (int p = 6; p < 8; p++) begin
            send('{8'hA8 | 8'(p), 8'h55});
            chk("bad pipe", {beats.size() == 0, ack_pending}, 3'b110);
        end
        $display("test ack done");
    endtask

    task automatic t_noack();
        logic [7:0] q[$] = '{CMD_NOACK_PL};
        for (int i = 0; i < 33; i++)
            q.push_back(8'(i));
        send(q);
        chk("noack beats", beats.size(), 33);
        for (int i = 0; i < 32; i++)
            chk("noack byte", {beats[i].kind, beats[i].index, beats[i].data}, {K_NOACK_PL, 6'(i), 8'(i)});
        chk("noack end", {beats[32].frame_end, beats[32].index}, {1'b1, PAYLOAD_MAX});
        $display("test noack done");
    endtask

    task automatic t_stall();
        logic [7:0] q[$] = '{CMD_NOACK_PL};
        for (int i = 0; i < 8; i++)
            q.push_back(8'(8'hC0 + i));
        beat_ready_i <= 1'b0;
        send(q);
        chk("stall flags", {beat_valid, overrun}, 2'b11);
        beat_ready_i <= 1'b1;
        repeat (10) @(posedge core_clk_i);
        for (int i = 0; i < 4; i++)
            chk("stall order", {beats[i].index, beats[i].data}, {6'(i), 8'(8'hC0 + i)});
        chk("drained", beat_valid, 1'b0);
        send('{CMD_IDLE_STATUS});
        chk("overrun clear", overrun, 1'b0);
        $display("test stall done");
    endtask

    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(posedge core_clk_i);
        t_locked();
        t_activate();
        t_bank();
        t_ack();
        t_noack();
        t_stall();
        wrap_up();
    end
endmodule // tb_top
